/* File: fwl_pkg.sv */
// package of the flash lock and write-suspend host controller
// assumes: one 100 MHz clock, apb software port, 8-bit flash data bus
`default_nettype none
package fwl_pkg;
   // ************************************************************
   // timing
   // ************************************************************
   localparam int CLK_NS      = 10;                            // pclk period
   localparam int PHASE_NS    = 30;                            // least width of a strobe phase
   localparam int PHASE_CYC   = (PHASE_NS + CLK_NS - 1) / CLK_NS; // rounded up
   // ************************************************************
   // apb register map (byte addresses)
   // ************************************************************
   localparam logic [7:0] OFS_CTRL   = 8'h00;  // bit0 high voltage reset-pin request
   localparam logic [7:0] OFS_ADDR   = 8'h04;  // flash target address
   localparam logic [7:0] OFS_CMD    = 8'h08;  // write op code to start
   localparam logic [7:0] OFS_STATUS = 8'h0c;  // controller and flash status
   localparam int ST_BUSY    = 0;
   localparam int ST_SUSP    = 1;
   localparam int ST_REFUSED = 2;
   localparam int ST_UNKNOWN = 3;
   localparam int ST_SR_LSB  = 8;
   // ************************************************************
   // flash status flag positions
   // ************************************************************
   localparam int READY_FLAG_BIT          = 7;
   localparam int ERASE_OR_CLEAR_ERR_BIT  = 5;
   localparam int WRITE_OR_SET_ERR_BIT    = 4;
   localparam int WRITE_SUSPENDED_BIT     = 2;
   // ************************************************************
   // flash command bytes
   // ************************************************************
   localparam logic [7:0] FC_READ_ARRAY  = 8'hff;
   localparam logic [7:0] FC_READ_STATUS = 8'h70;
   localparam logic [7:0] FC_CLR_STATUS  = 8'h50;
   localparam logic [7:0] FC_SUSPEND     = 8'hb0;
   localparam logic [7:0] FC_RESUME      = 8'hd0;
   localparam logic [7:0] FC_LOCK_SETUP  = 8'h60;
   localparam logic [7:0] FC_BLOCK_CONF  = 8'h01;
   localparam logic [7:0] FC_MASTER_CONF = 8'hf1;
   localparam logic [7:0] FC_CLEAR_CONF  = 8'hd0;
   // ************************************************************
   // software operations
   // ************************************************************
   typedef enum logic [2:0] {
      OP_READ_ARRAY = 3'h0, OP_READ_STATUS = 3'h1, OP_CLR_STATUS = 3'h2, OP_SUSPEND = 3'h3,
      OP_RESUME = 3'h4, OP_SET_BLOCK = 3'h5, OP_SET_MASTER = 3'h6, OP_CLEAR_LOCKS = 3'h7
   } fwl_op_e;
   typedef enum logic [5:0] {
      S_IDLE = 6'h01, S_WSET = 6'h02, S_WREL = 6'h04, S_RSET = 6'h08, S_RREL = 6'h10,
      S_DONE = 6'h20
   } fwl_state_e;
   // flash pin group driven by the controller
   typedef struct packed {
      logic        ce_n;
      logic        oe_n;
      logic        we_n;
      logic        dq_oe;
      logic [7:0]  dq_out;
      logic [19:0] addr;
      logic        rp_hv;
   } fwl_pins_s;
   // byte sent in write cycle idx of an operation
   function automatic logic [7:0] fwl_cmd_byte(input fwl_op_e op, input logic idx,
                                               input logic auto_clr);
      logic [7:0] b;
      b = FC_READ_ARRAY;
      if (auto_clr) begin
         b = FC_CLR_STATUS;
      end else begin
         case (op)
            OP_READ_STATUS: b = FC_READ_STATUS;
            OP_CLR_STATUS:  b = FC_CLR_STATUS;
            OP_SUSPEND:     b = FC_SUSPEND;
            OP_RESUME:      b = FC_RESUME;
            OP_SET_BLOCK:   b = idx ? FC_BLOCK_CONF : FC_LOCK_SETUP;
            OP_SET_MASTER:  b = idx ? FC_MASTER_CONF : FC_LOCK_SETUP;
            OP_CLEAR_LOCKS: b = idx ? FC_CLEAR_CONF : FC_LOCK_SETUP;
            default:        b = FC_READ_ARRAY;
         endcase
      end
      return b;
   endfunction
endpackage
`default_nettype wire

/* File: fwl_tick.sv */
// phase timer of the flash host controller
// assumes: restarted by clr whenever the sequencer changes state
`timescale 1ns/1ps
`default_nettype none
module fwl_tick (
   input  wire logic pclk,    // system clock
   input  wire logic presetn, // async reset, low active
   input  wire logic clr,     // restart the phase
   output logic      tick     // one-cycle pulse at phase end
);
   import fwl_pkg::*;
   logic [7:0] cnt_q;
   // counts one strobe phase, pulses at its last cycle
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cnt_q <= 8'h00;
         tick  <= 1'b0;
      end else if (clr) begin
         cnt_q <= 8'h00;
         tick  <= 1'b0;
      end else begin
         tick  <= (cnt_q == 8'(PHASE_CYC - 2)) || (PHASE_CYC < 2);
         cnt_q <= (cnt_q == 8'(PHASE_CYC - 1)) ? 8'h00 : cnt_q + 8'h01;
      end
   end
endmodule // fwl_tick
`default_nettype wire

/* File: fwl_host.sv */
// host controller that drives a parallel flash through its pins
// assumes: apb software port, flash answers asynchronously, inputs synchronous
//
// Local design decisions: the APB slave port and the register offsets.
`timescale 1ns/1ps
`default_nettype none
module fwl_host (
   input  wire logic              pclk,         // 100 MHz clock
   input  wire logic              presetn,      // async reset, low active
   input  wire logic              psel,         // apb select
   input  wire logic              penable,      // apb access phase
   input  wire logic              pwrite,       // apb write
   input  wire logic [7:0]        paddr,        // apb byte address
   input  wire logic [31:0]       pwdata,       // apb write data
   output logic      [31:0]       prdata,       // apb read data
   output logic                   pready,       // apb ready
   output logic                   pslverr,      // apb error, unmapped address
   output fwl_pkg::fwl_pins_s     flash_pins,   // strobes, address, data drive
   input  wire logic [7:0]        dq_in,        // flash data in
   input  wire logic              ready_busy_output // flash ready, high when ready
);
   import fwl_pkg::*;
   // ************************************************************
   // state
   // ************************************************************
   typedef struct packed {
      fwl_state_e  st;
      fwl_op_e     op;
      logic        idx;
      logic        auto_clr;
      logic [19:0] addr;
      logic        susp;
      logic        refused;
      logic        unknown;
      logic [7:0]  sr;
      fwl_pins_s   pins;
      logic [31:0] prdata;
      logic        pready;
      logic        pslverr;
   } fwl_regs_s;
   fwl_regs_s r_q, r_d;
   logic tick;
   logic setup_ph;
   logic start;
   logic acc;
   logic allowed;
   logic is_lock;
   logic ready_now;
   assign setup_ph  = psel && !penable;
   // completing edge of a transfer: access phase with pready sampled high
   assign acc       = psel && penable && r_q.pready;
   assign start     = acc && pwrite && (paddr == OFS_CMD) && (r_q.st == S_IDLE);
   assign allowed   = !r_q.susp || pwdata[2:0] == OP_READ_ARRAY
                      || pwdata[2:0] == OP_READ_STATUS || pwdata[2:0] == OP_RESUME;
   assign is_lock   = r_q.op == OP_SET_BLOCK || r_q.op == OP_SET_MASTER;
   // sampled status byte, never the released data bus, plus the ready pin
   assign ready_now = r_q.sr[READY_FLAG_BIT] && ready_busy_output;
   // phase timer restarts on every state change
   fwl_tick u_tick (
      .pclk    (pclk),
      .presetn (presetn),
      .clr     (r_d.st != r_q.st),
      .tick    (tick)
   );
   // ************************************************************
   // next state
   // ************************************************************
   always_comb begin
      r_d = r_q;
      r_d.pready  = 1'b0;
      r_d.pslverr = 1'b0;
      // writes take effect only at the completing edge of the transfer
      if (acc && pwrite) begin
         if (paddr == OFS_CTRL) begin
            r_d.pins.rp_hv = pwdata[0];
         end
         if (paddr == OFS_ADDR && r_q.st == S_IDLE) begin
            r_d.addr = pwdata[19:0];
         end
      end
      // apb slave: answers in the first access cycle
      if (setup_ph) begin
         r_d.pready = 1'b1;
         r_d.prdata = 32'h0000_0000;
         case (paddr)
            OFS_CTRL: r_d.prdata[0] = r_q.pins.rp_hv;
            OFS_ADDR: r_d.prdata[19:0] = r_q.addr;
            OFS_CMD: r_d.prdata[2:0] = r_q.op;
            OFS_STATUS: begin
               r_d.prdata[ST_BUSY]    = r_q.st != S_IDLE;
               r_d.prdata[ST_SUSP]    = r_q.susp;
               r_d.prdata[ST_REFUSED] = r_q.refused;
               r_d.prdata[ST_UNKNOWN] = r_q.unknown;
               r_d.prdata[ST_SR_LSB +: 8] = r_q.sr;
            end
            default: r_d.pslverr = 1'b1;
         endcase
      end
      // sequencer
      case (r_q.st)
         S_IDLE: begin
            if (start) begin
               if (allowed) begin
                  r_d.op       = fwl_op_e'(pwdata[2:0]);
                  r_d.idx      = 1'b0;
                  r_d.auto_clr = 1'b0;
                  r_d.refused  = 1'b0;
                  r_d.st       = S_WSET;
               end else begin
                  r_d.refused  = 1'b1;
               end
            end
         end
         S_WSET: begin
            r_d.pins.ce_n   = 1'b0;
            r_d.pins.we_n   = 1'b0;
            r_d.pins.dq_oe  = 1'b1;
            r_d.pins.addr   = r_q.addr;
            r_d.pins.dq_out = fwl_cmd_byte(r_q.op, r_q.idx, r_q.auto_clr);
            if (tick) begin
               r_d.st = S_WREL;
            end
         end
         S_WREL: begin
            r_d.pins.ce_n = 1'b1;
            r_d.pins.we_n = 1'b1;
            if (tick) begin
               r_d.pins.dq_oe = 1'b0;
               if (r_q.auto_clr || r_q.op == OP_READ_ARRAY || r_q.op == OP_CLR_STATUS
                   || r_q.op == OP_RESUME) begin
                  if (r_q.op == OP_RESUME) begin
                     r_d.susp = 1'b0;
                  end
                  r_d.st = S_DONE;
               end else if (!r_q.idx && r_q.op >= OP_SET_BLOCK) begin
                  r_d.idx = 1'b1;                  // confirm write follows
                  r_d.st  = S_WSET;
               end else begin
                  r_d.st = S_RSET;
               end
            end
         end
         S_RSET: begin
            r_d.pins.ce_n = 1'b0;
            r_d.pins.oe_n = 1'b0;
            if (tick) begin
               r_d.sr = dq_in;
               r_d.st = S_RREL;
            end
         end
         S_RREL: begin
            r_d.pins.ce_n = 1'b1;
            r_d.pins.oe_n = 1'b1;
            if (tick) begin
               if (!r_q.sr[READY_FLAG_BIT] || (r_q.op != OP_READ_STATUS && !ready_now)) begin
                  r_d.st = S_RSET;                 // lower flags invalid, poll again
               end else begin
                  r_d.st = S_DONE;
                  if (r_q.op == OP_SUSPEND) begin
                     r_d.susp = r_q.sr[WRITE_SUSPENDED_BIT];
                  end
                  if (is_lock && r_q.sr[WRITE_OR_SET_ERR_BIT]) begin
                     r_d.auto_clr = 1'b1;
                     r_d.st       = S_WSET;
                  end
                  if (r_q.op == OP_CLEAR_LOCKS) begin
                     r_d.unknown = r_q.sr[ERASE_OR_CLEAR_ERR_BIT];
                     if (r_q.sr[ERASE_OR_CLEAR_ERR_BIT]) begin
                        r_d.auto_clr = 1'b1;
                        r_d.st       = S_WSET;
                     end
                  end
               end
            end
         end
         S_DONE: r_d.st = S_IDLE;
         default: r_d.st = S_IDLE;
      endcase
   end
   // ************************************************************
   // registers
   // ************************************************************
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         r_q          <= '0;
         r_q.st       <= S_IDLE;
         r_q.op       <= OP_READ_ARRAY;
         r_q.pins.ce_n <= 1'b1;
         r_q.pins.oe_n <= 1'b1;
         r_q.pins.we_n <= 1'b1;
      end else begin
         r_q <= r_d;
      end
   end
   assign prdata     = r_q.prdata;
   assign pready     = r_q.pready;
   assign pslverr    = r_q.pslverr;
   assign flash_pins = r_q.pins;
   // ************************************************************
   // assertions
   // ************************************************************
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);
   AST_SUSP_FILTER: assert property (start && !allowed |=> r_q.st == S_IDLE && r_q.refused)
      else $error("forbidden command started during suspend");
   AST_CONFIRM: assert property (r_q.st == S_WREL && tick && !r_q.idx && !r_q.auto_clr
                                 && r_q.op >= OP_SET_BLOCK |=> r_q.st == S_WSET && r_q.idx)
      else $error("lock setup not followed by confirm");
   AST_WE_IN_CE: assert property (!flash_pins.we_n |-> !flash_pins.ce_n && flash_pins.dq_oe
                                  && flash_pins.oe_n)
      else $error("write strobe outside chip select");
   AST_NO_CLR_SUSP: assert property (r_q.st == S_WSET && fwl_cmd_byte(r_q.op, r_q.idx,
                                     r_q.auto_clr) == FC_CLR_STATUS |-> !r_q.susp)
      else $error("clear status sent while suspended");
   AST_SET_ERR: assert property (r_q.st == S_RREL && tick && ready_now && r_q.sr[7] && is_lock
                                 && r_q.sr[WRITE_OR_SET_ERR_BIT] |=> r_q.auto_clr
                                 ##[1:40] !flash_pins.we_n && flash_pins.dq_out == FC_CLR_STATUS)
      else $error("set error not cleared");
   AST_CLR_ERR: assert property (r_q.st == S_RREL && tick && ready_now && r_q.sr[7]
                                 && r_q.op == OP_CLEAR_LOCKS && r_q.sr[ERASE_OR_CLEAR_ERR_BIT]
                                 |=> r_q.unknown && r_q.st == S_WSET)
      else $error("clear error not handled");
   AST_UNKNOWN: assert property ($rose(r_q.unknown) |-> $past(r_q.op) == OP_CLEAR_LOCKS)
      else $error("lock state flagged unknown without clear");
   COV_SUSPEND: cover property (r_q.st == S_DONE && r_q.op == OP_SUSPEND && r_q.susp);
   COV_LOCK_ERR: cover property (r_q.auto_clr && r_q.st == S_WSET && is_lock);
   COV_REFUSED: cover property (start && !allowed);
endmodule // fwl_host
`default_nettype wire

/* File: fwl_flash_model.sv */
// behavioural parallel flash: status flags, byte write suspend, lock bits
// assumes: pins come from fwl_host, sampled on pclk; the bench resolves dq
`timescale 1ns/1ps
`default_nettype none
module fwl_flash_model #(
   parameter int BW_CYC = 3000, // internal byte write length
   parameter int LK_CYC = 20,   // lock operation length
   parameter int SP_CYC = 4     // suspend latency
) (
   input  wire logic               pclk,              // sample clock
   input  wire fwl_pkg::fwl_pins_s pins,              // controller pins
   input  wire logic               bw_start,          // start an internal byte write
   input  wire logic               vpp_low,           // supply at lockout level
   output logic [7:0]              dq,                // data toward controller
   output logic                    ready_busy_output, // high when ready
   output logic                    master_q,          // master lock bit
   output logic [15:0]             locks_q,           // block lock bits
   output int                      n_cmd              // write cycles seen
);
   import fwl_pkg::*;
   logic [7:0] sr_q = 8'h00;
   logic [7:0] last_q = 8'h00;
   logic       setup_q = 1'b0;
   logic       stat_q = 1'b0;
   logic       susp_q = 1'b0;
   logic       wr_q = 1'b0;
   logic       we_q = 1'b1;
   logic       ce_q = 1'b1;
   logic       rd;
   int         busy_q = 0;
   int         rem_q = 0;
   initial master_q = 1'b0;
   initial locks_q = 16'h0000;
   initial n_cmd = 0;
   // ready while no algorithm runs; reads give status, or 8'h5a in array mode; unread, a pattern that changes each cycle
   assign ready_busy_output = (busy_q == 0);
   assign rd = !pins.ce_n && !pins.oe_n;
   assign dq = !rd ? ~last_q : !stat_q ? 8'h5a :
               {ready_busy_output, 1'b0, sr_q[5:3], susp_q, sr_q[1], 1'b0};
   // command decoding on the rising edge of the write strobe
   always @(posedge pclk) begin
      we_q <= pins.we_n;
      ce_q <= pins.ce_n;
      last_q <= dq;
      if (busy_q > 0) busy_q <= busy_q - 1;
      if (busy_q == 1 && !susp_q) wr_q <= 1'b0;
      if (bw_start) begin
         stat_q <= 1'b1;
         if (locks_q[pins.addr[19:16]] && !pins.rp_hv) begin
            sr_q <= sr_q | 8'h12; // locked block refuses the write
         end else begin
            wr_q <= 1'b1; // unlocked or overridden
            busy_q <= BW_CYC;
         end
      end
      // strobes rise together, so chip select is taken from the cycle before
      if (pins.we_n && !we_q && !ce_q) begin
         n_cmd <= n_cmd + 1;
         if (setup_q) begin
            setup_q <= 1'b0;
            busy_q <= LK_CYC;
            case (pins.dq_out)
               FC_BLOCK_CONF: if (master_q && !pins.rp_hv) sr_q <= sr_q | 8'h12;
                  else locks_q[pins.addr[19:16]] <= 1'b1;
               FC_MASTER_CONF: if (!pins.rp_hv) sr_q <= sr_q | 8'h12;
                  else master_q <= 1'b1; // never cleared
               FC_CLEAR_CONF: if (vpp_low) sr_q <= sr_q | 8'h28;
                  else if (master_q && !pins.rp_hv) sr_q <= sr_q | 8'h22;
                  else locks_q <= 16'h0000; // all at once
               default: sr_q <= sr_q | 8'h30;
            endcase
         end else begin
            case (pins.dq_out)
               FC_READ_STATUS: stat_q <= 1'b1;
               FC_READ_ARRAY: stat_q <= 1'b0;
               FC_CLR_STATUS: if (!susp_q) sr_q <= 8'h00;
               FC_SUSPEND: if (wr_q && !susp_q) begin
                  susp_q <= 1'b1;
                  rem_q <= busy_q;
                  busy_q <= SP_CYC;
                  stat_q <= 1'b1;
               end
               FC_RESUME: if (susp_q) begin
                  susp_q <= 1'b0;
                  busy_q <= rem_q;
                  stat_q <= 1'b1;
               end
               FC_LOCK_SETUP: if (!susp_q) begin
                  setup_q <= 1'b1;
                  stat_q <= 1'b1;
               end
               default: ;
            endcase
         end
      end
   end
endmodule // fwl_flash_model
`default_nettype wire

/* File: fwl_host_tb.sv */
// testbench of the flash lock and write-suspend host controller
// assumes: fwl_host faces fwl_flash_model; apb driven on rising edges
`timescale 1ns/1ps
`default_nettype none
module fwl_host_tb;
   import fwl_pkg::*;
   logic        pclk = 1'b0;
   logic        presetn = 1'b0;
   logic        psel = 1'b0;
   logic        penable = 1'b0;
   logic        pwrite = 1'b0;
   logic [7:0]  paddr = 8'h00;
   logic [31:0] pwdata = 32'h0;
   logic [31:0] prdata, rd, st;
   logic        pready, pslverr, err, rb, master;
   logic        bw_start = 1'b0;
   logic        vpp_low = 1'b0;
   logic [7:0]  dq_in, fdq;
   logic [15:0] locks;
   fwl_pins_s   pins;
   int          n_cmd, n0;
   int          n_mismatch = 0;
   int          compares = 0;
   always #5 pclk = ~pclk;
   // data wire resolved from the controller's enable
   assign dq_in = pins.dq_oe ? pins.dq_out : fdq;
   fwl_host uut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .flash_pins(pins), .dq_in(dq_in), .ready_busy_output(rb));
   fwl_flash_model fm (.pclk(pclk), .pins(pins), .bw_start(bw_start), .vpp_low(vpp_low),
      .dq(fdq), .ready_busy_output(rb), .master_q(master), .locks_q(locks), .n_cmd(n_cmd));
   // ************************************************************
   // tasks
   // ************************************************************
   task automatic print_verdict;
      $display("mismatches %0d compares %0d", n_mismatch, compares);
      if (n_mismatch == 0 && compares > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask
   task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
      compares++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("MISMATCH %s expected %h seen %h", name, exp, seen);
      end
   endtask
   // one apb transfer: setup, then access held until pready is sampled high
   task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
      int i;
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      for (i = 0; i < 50; i++) begin
         @(posedge pclk);
         if (pready === 1'b1) break;
      end
      if (i == 50) begin
         n_mismatch++;
         print_verdict();
      end
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   // start an operation and poll until the controller is idle
   task automatic do_op(input fwl_op_e op, input logic [19:0] a, input logic hv);
      int i;
      apb(1'b1, OFS_CTRL, {31'h0, hv});
      apb(1'b1, OFS_ADDR, {12'h0, a});
      apb(1'b1, OFS_CMD, {29'h0, op});
      for (i = 0; i < 500; i++) begin
         apb(1'b0, OFS_STATUS, 32'h0);
         if (rd[ST_BUSY] === 1'b0) break;
      end
      if (i == 500) begin
         n_mismatch++;
         print_verdict();
      end
      st = rd;
   endtask
   task automatic op_chk(input fwl_op_e op, input logic [19:0] a, input logic hv,
                         input logic [7:0] e);
      do_op(op, a, hv);
      check("flash status", 32'(st[15:8]), 32'(e));
   endtask
   // ************************************************************
   // main sequence
   // ************************************************************
   initial begin
      repeat (8) @(posedge pclk);
      check("ce_n in reset", 32'(pins.ce_n), 32'h1);
      check("dq_oe in reset", 32'(pins.dq_oe), 32'h0);
      presetn <= 1'b1;
      op_chk(OP_SET_MASTER, 20'h00000, 1'b0, 8'h92);
      check("master", 32'(master), 32'h0);
      op_chk(OP_SET_BLOCK, 20'h10000, 1'b0, 8'h80);
      check("locks", 32'(locks), 32'h2);
      op_chk(OP_SET_MASTER, 20'h00000, 1'b1, 8'h80);
      check("master", 32'(master), 32'h1);
      op_chk(OP_SET_BLOCK, 20'h20000, 1'b0, 8'h92);
      op_chk(OP_SET_BLOCK, 20'h30000, 1'b1, 8'h80);
      check("locks", 32'(locks), 32'ha);
      // byte write into locked block 3 with the reset pin at normal high
      apb(1'b1, OFS_CTRL, 32'h0);
      bw_start <= 1'b1;
      @(posedge pclk);
      bw_start <= 1'b0;
      op_chk(OP_READ_STATUS, 20'h30000, 1'b0, 8'h92);
      do_op(OP_CLR_STATUS, 20'h00000, 1'b0);
      op_chk(OP_CLEAR_LOCKS, 20'h00000, 1'b0, 8'ha2);
      check("locks unknown", 32'(st[ST_UNKNOWN]), 32'h1);
      do_op(OP_CLR_STATUS, 20'h00000, 1'b0);
      vpp_low <= 1'b1;
      op_chk(OP_CLEAR_LOCKS, 20'h00000, 1'b1, 8'ha8);
      vpp_low <= 1'b0;
      do_op(OP_CLR_STATUS, 20'h00000, 1'b0);
      op_chk(OP_CLEAR_LOCKS, 20'h00000, 1'b1, 8'h80);
      check("locks", 32'(locks), 32'h0);
      check("locks unknown", 32'(st[ST_UNKNOWN]), 32'h0);
      check("master", 32'(master), 32'h1);
      // suspend an internal byte write, then try forbidden commands
      bw_start <= 1'b1;
      @(posedge pclk);
      bw_start <= 1'b0;
      op_chk(OP_SUSPEND, 20'h40000, 1'b0, 8'h84);
      check("suspended", 32'(st[ST_SUSP]), 32'h1);
      check("ready pin", 32'(rb), 32'h1);
      n0 = n_cmd;
      do_op(OP_CLR_STATUS, 20'h00000, 1'b0);
      check("refused", 32'(st[ST_REFUSED]), 32'h1);
      do_op(OP_SET_BLOCK, 20'h40000, 1'b0);
      check("refused", 32'(st[ST_REFUSED]), 32'h1);
      check("flash writes", 32'(n_cmd), 32'(n0));
      op_chk(OP_READ_STATUS, 20'h00000, 1'b0, 8'h84);
      do_op(OP_READ_ARRAY, 20'h50000, 1'b0);
      check("refused", 32'(st[ST_REFUSED]), 32'h0);
      check("flash writes", 32'(n_cmd), 32'(n0 + 2));
      do_op(OP_RESUME, 20'h40000, 1'b0);
      check("suspended", 32'(st[ST_SUSP]), 32'h0);
      @(negedge pclk);
      check("ready pin", 32'(rb), 32'h0);
      apb(1'b0, 8'h10, 32'h0);
      check("unmapped error", 32'(err), 32'h1);
      print_verdict();
   end
endmodule // fwl_host_tb
`default_nettype wire
